//--- logic/fstcw_map.svh
// Register offsets, field positions, reset values, tag codes and interrupt bits of the status/control/tag bank
`ifndef FSTCW_MAP_SVH
`define FSTCW_MAP_SVH

`define FSTCW_OFF_CTRL      8'h00
`define FSTCW_OFF_STATUS    8'h04
`define FSTCW_OFF_TAG       8'h08
`define FSTCW_OFF_TAGSAVE   8'h0c
`define FSTCW_OFF_CMD       8'h10
`define FSTCW_OFF_DATA0     8'h14
`define FSTCW_OFF_DATA1     8'h18
`define FSTCW_OFF_DATA2     8'h1c
`define FSTCW_OFF_CLASS     8'h20
`define FSTCW_OFF_IRQ_STAT  8'h24
`define FSTCW_OFF_IRQ_MASK  8'h28

`define FSTCW_CTRL_RESET    16'h037f
`define FSTCW_TAG_RESET     16'hffff
`define FSTCW_CTRL_INF_BIT  12
`define FSTCW_CTRL_IM_BIT   0

`define FSTCW_TAG_VALID     2'h0
`define FSTCW_TAG_ZERO      2'h1
`define FSTCW_TAG_SPECIAL   2'h2
`define FSTCW_TAG_EMPTY     2'h3

`define FSTCW_CMD_OP_MSB    3
`define FSTCW_CMD_ARG_BIT   4
`define FSTCW_CMD_Q_LSB     5

`define FSTCW_IRQ_STACK     0
`define FSTCW_IRQ_INVALID   1
`define FSTCW_IRQ_PTAN      2
`define FSTCW_IRQ_W         3

`endif

//--- logic/fstcw_pkg.sv
// Types shared by the status/control/tag bank
package fstcw_pkg;

	typedef enum logic [3:0] {
		FSTCW_OP_NOP       = 4'h0,
		FSTCW_OP_INIT      = 4'h1,
		FSTCW_OP_PREM_PART = 4'h2,
		FSTCW_OP_PREM_DONE = 4'h3,
		FSTCW_OP_PTAN      = 4'h4,
		FSTCW_OP_PUSH      = 4'h5,
		FSTCW_OP_POP       = 4'h6,
		FSTCW_OP_INVALID   = 4'h7,
		FSTCW_OP_CLEX      = 4'h8
	} fstcw_op_t;

	typedef struct packed {
		logic       busy;
		logic       c3;
		logic [2:0] top;
		logic       c2;
		logic       c1;
		logic       c0;
		logic       es;
		logic       sf;
		logic [4:0] rsv;
		logic       ie;
	} fstcw_status_t;

endpackage

//--- logic/fstcw_classify.sv
// Derives a tag from the contents of one 80-bit extended register
`timescale 1ns/100ps
`include "fstcw_map.svh"

module fstcw_classify (
	input  wire logic [79:0] value,
	output logic      [1:0]  tag
);
	wire        exp_zero = (value[78:64] == 15'h0000);
	wire        exp_ones = (value[78:64] == 15'h7fff);
	wire        sig_zero = (value[63:0] == 64'h0000000000000000);
	wire        unnormal = ~exp_zero & ~value[63];

	// Denormals, unnormals, infinities and NaNs all count as special
	assign tag = (exp_zero & sig_zero)                ? `FSTCW_TAG_ZERO :
	             (exp_zero | exp_ones | unnormal)     ? `FSTCW_TAG_SPECIAL :
	                                                    `FSTCW_TAG_VALID;
endmodule

//--- logic/fstcw_tag_build.sv
// Rebuilds the tag word from register contents, keeping only the empty marks of the stored word
`timescale 1ns/100ps
`include "fstcw_map.svh"

module fstcw_tag_build (
	input  wire logic [7:0][79:0] regs,
	input  wire logic [15:0]      tag_in,
	output logic      [15:0]      tag_out
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_slot
			logic [1:0] derived;
			fstcw_classify u_cls (
				.value (regs[i]),
				.tag   (derived)
			);
			assign tag_out[2*i +: 2] = (tag_in[2*i +: 2] == `FSTCW_TAG_EMPTY) ? `FSTCW_TAG_EMPTY : derived;
		end
	endgenerate
endmodule

//--- logic/fstcw_top.sv
// Floating-point status, control and tag word bank with APB register access
//
// Summary of operation
// - Initialise, partial-remainder-incomplete and reset clear CONDITION_CODE_BITS to zero.
// - Status bit 10 flags an incomplete partial tangent reduction.
// - Infinity arithmetic is always affine; projective is never used.
// - Control bit 12 is read/write but steers nothing.
// - Stack overflow or underflow sets the invalid-operation flag, status bit 0.
// - Stack overflow or underflow also sets stack-fault flag, status bit 6.
// - On a stack fault, status bit 9 tells overflow from underflow.
// - Numeric invalid operations leave the stack-fault flag as it stands, neither setting nor clearing it.
// - A loaded tag of 11 means empty; 00, 01, 10 mean nonempty.
// - Nonempty operands are classified from register contents, not the tag.
// - Tag store rebuilds each nonempty tag from the register contents first.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "fstcw_map.svh"

module fstcw_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	// Architectural state
	logic [15:0]              ctrl_word;
	logic [3:0]               cc;
	logic                     ie;
	logic                     sf;
	logic [2:0]               top;
	logic [15:0]              tag_word;
	logic [31:0]              data0;
	logic [31:0]              data1;
	logic [15:0]              data2;
	logic [`FSTCW_IRQ_W-1:0]  irq_stat;
	logic [`FSTCW_IRQ_W-1:0]  irq_mask;
	logic [79:0]              stack_regs [0:7];

	logic [3:0]               next_cc;
	logic                     next_ie;
	logic                     next_sf;
	logic [2:0]               next_top;
	logic [15:0]              next_tag;
	logic [`FSTCW_IRQ_W-1:0]  next_ev;

	// APB phase decode
	wire setup   = psel & ~penable;
	wire access  = psel & penable & pready;
	wire wr_done = access & pwrite;
	wire rd_done = access & ~pwrite;

	wire hit_ctrl     = (paddr == `FSTCW_OFF_CTRL);
	wire hit_status   = (paddr == `FSTCW_OFF_STATUS);
	wire hit_tag      = (paddr == `FSTCW_OFF_TAG);
	wire hit_tagsave  = (paddr == `FSTCW_OFF_TAGSAVE);
	wire hit_cmd      = (paddr == `FSTCW_OFF_CMD);
	wire hit_data0    = (paddr == `FSTCW_OFF_DATA0);
	wire hit_data1    = (paddr == `FSTCW_OFF_DATA1);
	wire hit_data2    = (paddr == `FSTCW_OFF_DATA2);
	wire hit_class    = (paddr == `FSTCW_OFF_CLASS);
	wire hit_irq_stat = (paddr == `FSTCW_OFF_IRQ_STAT);
	wire hit_irq_mask = (paddr == `FSTCW_OFF_IRQ_MASK);
	wire hit_any      = hit_ctrl | hit_status | hit_tag | hit_tagsave | hit_cmd | hit_data0 | hit_data1
	                  | hit_data2 | hit_class | hit_irq_stat | hit_irq_mask;

	// Write strobes, one per writable register, and the tag-save read strobe, taken at the access edge
	wire wr_ctrl      = wr_done & hit_ctrl;
	wire wr_tag       = wr_done & hit_tag;
	wire wr_data0     = wr_done & hit_data0;
	wire wr_data1     = wr_done & hit_data1;
	wire wr_data2     = wr_done & hit_data2;
	wire wr_irq_stat  = wr_done & hit_irq_stat;
	wire wr_irq_mask  = wr_done & hit_irq_mask;
	wire rd_tagsave   = rd_done & hit_tagsave;

	// Command decode
	wire                 cmd_go  = wr_done & hit_cmd;
	fstcw_pkg::fstcw_op_t cmd_op;
	assign cmd_op = fstcw_pkg::fstcw_op_t'(pwdata[`FSTCW_CMD_OP_MSB:0]);
	wire                 cmd_arg = pwdata[`FSTCW_CMD_ARG_BIT];
	wire [2:0]           cmd_q   = pwdata[`FSTCW_CMD_Q_LSB +: 3];

	// Stack geometry
	// Top wraps modulo eight, so pushes and pops walk the tag word as a ring
	wire [2:0]  push_top   = top - 3'h1;
	wire [2:0]  pop_top    = top + 3'h1;
	wire [1:0]  tag_at_top = tag_word[{top, 1'b0} +: 2];
	wire [1:0]  tag_at_new = tag_word[{push_top, 1'b0} +: 2];
	wire        st0_empty  = (tag_at_top == `FSTCW_TAG_EMPTY);
	wire        overflow   = (tag_at_new != `FSTCW_TAG_EMPTY);
	// The staged operand is only consistent once all three data words are written
	wire [79:0] staged     = {data2, data1, data0};

	// Command strobes shared by the register processes
	wire        op_init    = cmd_go & (cmd_op == fstcw_pkg::FSTCW_OP_INIT);
	wire        push_ok    = cmd_go & (cmd_op == fstcw_pkg::FSTCW_OP_PUSH) & ~overflow;

	// Contents-based classification of staged data and of ST(0)
	logic [1:0] staged_tag;
	logic [1:0] st0_class;
	logic [15:0] rebuilt_tag;
	logic [7:0][79:0] regs_flat;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flat
			assign regs_flat[gi] = stack_regs[gi];
		end
	endgenerate

	fstcw_classify u_cls_staged (
		.value (staged),
		.tag   (staged_tag)
	);

	fstcw_classify u_cls_st0 (
		.value (stack_regs[top]),
		.tag   (st0_class)
	);

	fstcw_tag_build u_tag_build (
		.regs    (regs_flat),
		.tag_in  (tag_word),
		.tag_out (rebuilt_tag)
	);

	// Arithmetic sees only the stored tag's empty mark; the class comes from the register itself
	wire [1:0] operand_class = st0_empty ? `FSTCW_TAG_EMPTY : st0_class;

	// Control bit 12 is stored but nothing reads it for arithmetic; closure is hardwired affine
	wire       inf_affine = 1'b1;

	// Status word assembly
	fstcw_pkg::fstcw_status_t status_word;
	assign status_word.busy = 1'b0;
	assign status_word.c3   = cc[3];
	assign status_word.top  = top;
	assign status_word.c2   = cc[2];
	assign status_word.c1   = cc[1];
	assign status_word.c0   = cc[0];
	assign status_word.es   = ie & ~ctrl_word[`FSTCW_CTRL_IM_BIT];
	assign status_word.sf   = sf;
	assign status_word.rsv  = 5'h00;
	assign status_word.ie   = ie;

	// Read mux; write-only and unmapped offsets read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_ctrl) begin
			rd_mux = {16'h0000, ctrl_word};
		end else if (hit_status) begin
			rd_mux = {16'h0000, status_word};
		end else if (hit_tag) begin
			rd_mux = {16'h0000, tag_word};
		end else if (hit_tagsave) begin
			rd_mux = {16'h0000, rebuilt_tag};
		end else if (hit_data0) begin
			rd_mux = data0;
		end else if (hit_data1) begin
			rd_mux = data1;
		end else if (hit_data2) begin
			rd_mux = {16'h0000, data2};
		end else if (hit_class) begin
			rd_mux = {23'h000000, inf_affine, 6'h00, operand_class};
		end else if (hit_irq_stat) begin
			rd_mux = {29'h00000000, irq_stat};
		end else if (hit_irq_mask) begin
			rd_mux = {29'h00000000, irq_mask};
		end
	end

	// Status, stack and tag next-state
	always_comb begin
		next_cc  = cc;
		next_ie  = ie;
		next_sf  = sf;
		next_top = top;
		next_tag = tag_word;
		next_ev  = '0;
		if (wr_tag) begin
			// Stored as written; only the empty code is honoured afterwards
			next_tag = pwdata[15:0];
		end
		if (rd_tagsave) begin
			next_tag = rebuilt_tag;
		end
		if (cmd_go) begin
			case (cmd_op)
				fstcw_pkg::FSTCW_OP_INIT: begin
					next_cc  = 4'h0;
					next_ie  = 1'b0;
					next_sf  = 1'b0;
					next_top = 3'h0;
					next_tag = `FSTCW_TAG_RESET;
				end
				fstcw_pkg::FSTCW_OP_PREM_PART: begin
					next_cc = 4'h0;
				end
				fstcw_pkg::FSTCW_OP_PREM_DONE: begin
					// Quotient bits land in C0, C3, C1; C2 clear marks completion
					next_cc = {cmd_q[1], 1'b0, cmd_q[0], cmd_q[2]};
				end
				fstcw_pkg::FSTCW_OP_PTAN: begin
					next_cc[2] = cmd_arg;
					next_ev[`FSTCW_IRQ_PTAN] = cmd_arg;
				end
				fstcw_pkg::FSTCW_OP_PUSH: begin
					if (overflow) begin
						next_ie    = 1'b1;
						next_sf    = 1'b1;
						next_cc[1] = 1'b1;
						next_ev[`FSTCW_IRQ_STACK] = 1'b1;
					end else begin
						next_top = push_top;
						next_tag[{push_top, 1'b0} +: 2] = staged_tag;
					end
				end
				fstcw_pkg::FSTCW_OP_POP: begin
					if (st0_empty) begin
						next_ie    = 1'b1;
						next_sf    = 1'b1;
						next_cc[1] = 1'b0;
						next_ev[`FSTCW_IRQ_STACK] = 1'b1;
					end else begin
						next_top = pop_top;
						next_tag[{top, 1'b0} +: 2] = `FSTCW_TAG_EMPTY;
					end
				end
				fstcw_pkg::FSTCW_OP_INVALID: begin
					// Numeric invalid: stack-fault flag is left as it stands
					next_ie = 1'b1;
					next_ev[`FSTCW_IRQ_INVALID] = 1'b1;
				end
				fstcw_pkg::FSTCW_OP_CLEX: begin
					next_ie = 1'b0;
					next_sf = 1'b0;
				end
				default: begin
					next_cc = cc;
				end
			endcase
		end
	end

	// Sticky interrupt status: a new event wins over a same-cycle clear
	wire [`FSTCW_IRQ_W-1:0] irq_clr = wr_irq_stat ? pwdata[`FSTCW_IRQ_W-1:0] : '0;
	wire [`FSTCW_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | next_ev;
	// The level output lags the sticky bits by a cycle so that it leaves straight from a flop
	wire                    next_irq = |(irq_stat & irq_mask);

	// APB answer: always one wait-free access phase
	// Read data is captured at setup so that it already stands when pready is sampled
	wire next_pready  = setup;
	wire next_pslverr = setup & ~hit_any;
	wire capture_rd   = setup & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			if (capture_rd) begin
				prdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc       <= 4'h0;
			ie       <= 1'b0;
			sf       <= 1'b0;
			top      <= 3'h0;
			tag_word <= `FSTCW_TAG_RESET;
		end else begin
			cc       <= next_cc;
			ie       <= next_ie;
			sf       <= next_sf;
			top      <= next_top;
			tag_word <= next_tag;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_word <= `FSTCW_CTRL_RESET;
		end else if (op_init) begin
			ctrl_word <= `FSTCW_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_word <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data0 <= 32'h00000000;
			data1 <= 32'h00000000;
			data2 <= 16'h0000;
		end else begin
			if (wr_data0) begin
				data0 <= pwdata;
			end
			if (wr_data1) begin
				data1 <= pwdata;
			end
			if (wr_data2) begin
				data2 <= pwdata[15:0];
			end
		end
	end

	// Register file has no reset: contents only matter once a tag marks them nonempty
	always_ff @(posedge pclk) begin
		if (push_ok) begin
			stack_regs[push_top] <= staged;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_mask <= '0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_irq_mask) begin
				irq_mask <= pwdata[`FSTCW_IRQ_W-1:0];
			end
			irq <= next_irq;
		end
	end

endmodule

//--- tb/fstcw_host.sv
// APB host model that issues register transfers to the bank
`timescale 1ns/100ps
module fstcw_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines show no stale request
		pwrite <= ~w;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

//--- tb/fstcw_top_checker.sv
// Concurrent checks on the bank's APB and interrupt ports
`timescale 1ns/100ps
`include "fstcw_map.svh"
module fstcw_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	logic [3:0]  last_op;
	logic        last_arg;
	logic        ctrl_12;
	logic [15:0] tag_sh;
	logic        tag_ok;
	logic [`FSTCW_IRQ_W-1:0] mask_sh;
	wire         wr_acc = psel & penable & pready & pwrite;
	wire         rd_acc = psel & penable & pready & ~pwrite;
	wire         bad_addr = (paddr > 8'h28) | (|paddr[1:0]);
	wire         cmd_wr = wr_acc & (paddr == `FSTCW_OFF_CMD);
	wire         st_rd = rd_acc & (paddr == `FSTCW_OFF_STATUS);
	function automatic logic [7:0] empties(input logic [15:0] t);
		for (int i = 0; i < 8; i++)
			empties[i] = &t[2*i +: 2];
	endfunction
	// Reset is treated as an initialise, which leaves the same state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_op <= 4'h1;
			last_arg <= 1'b0;
			ctrl_12 <= 1'b0;
			tag_sh <= 16'hffff;
			tag_ok <= 1'b1;
			mask_sh <= '0;
		end else if (wr_acc && paddr == `FSTCW_OFF_IRQ_MASK) begin
			mask_sh <= pwdata[`FSTCW_IRQ_W-1:0];
		end else if (wr_acc && paddr == `FSTCW_OFF_CTRL) begin
			ctrl_12 <= pwdata[12];
		end else if (wr_acc && paddr == `FSTCW_OFF_TAG) begin
			tag_sh <= pwdata[15:0];
			tag_ok <= 1'b1;
		end else if (cmd_wr) begin
			last_op <= pwdata[3:0];
			last_arg <= pwdata[4];
			ctrl_12 <= (pwdata[3:0] == 4'h1) ? 1'b0 : ctrl_12;
			tag_sh <= (pwdata[3:0] == 4'h1) ? 16'hffff : tag_sh;
			// Pushes and pops move tags the shadow cannot follow
			tag_ok <= (pwdata[3:0] == 4'h1) | (tag_ok & (pwdata[3:0] != 4'h5) & (pwdata[3:0] != 4'h6));
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_only_access_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
	error_response_a: assert property (pready || pslverr |-> pready && pslverr == bad_addr)
		else $error("error response wrong");
	ctrl_bit12_a: assert property (rd_acc && paddr == `FSTCW_OFF_CTRL |-> prdata[12] == ctrl_12)
		else $error("control bit 12 not kept");
	affine_only_a: assert property (rd_acc && paddr == `FSTCW_OFF_CLASS |-> prdata[8])
		else $error("closure not affine");
	cc_cleared_a: assert property (st_rd && last_op inside {4'h1, 4'h2} |-> !prdata[14] && prdata[10:8] == 3'h0)
		else $error("condition codes not cleared");
	ptan_c2_a: assert property (st_rd && last_op == 4'h4 |-> prdata[10] == last_arg)
		else $error("tangent incomplete bit wrong");
	fault_sets_ie_a: assert property (st_rd && prdata[6] |-> prdata[0])
		else $error("stack fault without invalid flag");
	empty_kept_a: assert property (rd_acc && paddr == `FSTCW_OFF_TAGSAVE && tag_ok |->
		empties(prdata[15:0]) == empties(tag_sh)) else $error("empty tags not kept");
	cover property (cmd_wr && pwdata[3:0] == 4'h5);
	cover property (st_rd && prdata[6]);
	cover property (pslverr);
	cover property (irq);
	irq_masked_quiet_a: assert property (mask_sh == '0 |=> !irq)
		else $error("interrupt raised with every source masked");
endmodule
bind fstcw_top fstcw_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

//--- tb/fstcw_bench.sv
// Self-checking bench for the status, control and tag bank
`timescale 1ns/100ps
`include "fstcw_map.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module fstcw_bench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] q;
	logic        e;
	int          mismatches;
	int          total_checks;
	int          cycles;
	fstcw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	fstcw_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task automatic t_reset;
		rd(`FSTCW_OFF_CTRL);
		`CHK(q, 32'h037f)
		rd(`FSTCW_OFF_STATUS);
		`CHK(q, 32'h0)
		rd(`FSTCW_OFF_TAG);
		`CHK(q, 32'hffff)
	endtask
	task automatic t_cc;
		wr(`FSTCW_OFF_CTRL, 32'h137f);
		rd(`FSTCW_OFF_CTRL);
		`CHK(q, 32'h137f)
		rd(`FSTCW_OFF_CLASS);
		`CHK(q[8], 1'b1)
		wr(`FSTCW_OFF_CMD, 32'he3);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q & 32'h4700, 32'h4300)
		wr(`FSTCW_OFF_CMD, 32'h2);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q & 32'h4700, 32'h0)
		wr(`FSTCW_OFF_CMD, 32'he3);
		wr(`FSTCW_OFF_CMD, 32'h1);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q, 32'h0)
	endtask
	task automatic t_ptan;
		wr(`FSTCW_OFF_CMD, 32'h14);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q[10], 1'b1)
		wr(`FSTCW_OFF_CMD, 32'h4);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q[10], 1'b0)
	endtask
	task automatic t_stack;
		wr(`FSTCW_OFF_CMD, 32'h6);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q, 32'h41)
		wr(`FSTCW_OFF_CMD, 32'h8);
		wr(`FSTCW_OFF_DATA0, 32'h0);
		wr(`FSTCW_OFF_DATA1, 32'h80000000);
		wr(`FSTCW_OFF_DATA2, 32'h3fff);
		// Eight pushes fill the stack, the ninth overflows
		repeat (9)
			wr(`FSTCW_OFF_CMD, 32'h5);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q & 32'h0241, 32'h0241)
		wr(`FSTCW_OFF_CMD, 32'h1);
		wr(`FSTCW_OFF_CMD, 32'h7);
		rd(`FSTCW_OFF_STATUS);
		`CHK(q & 32'h41, 32'h1)
	endtask
	task automatic t_tags;
		wr(`FSTCW_OFF_CMD, 32'h5);
		for (int t = 0; t < 4; t++) begin
			wr(`FSTCW_OFF_TAG, {16'h0, t[1:0], 14'h3fff});
			rd(`FSTCW_OFF_CLASS);
			`CHK({q[8], q[1:0]}, {1'b1, ((t == 3) ? 2'h3 : 2'h0)})
			rd(`FSTCW_OFF_TAGSAVE);
			`CHK(q, (t == 3) ? 32'hffff : 32'h3fff)
		end
		wr(`FSTCW_OFF_DATA1, 32'h0);
		wr(`FSTCW_OFF_DATA2, 32'h0);
		wr(`FSTCW_OFF_CMD, 32'h5);
		rd(`FSTCW_OFF_TAGSAVE);
		`CHK(q, 32'hdfff)
	endtask
	task automatic t_irq;
		wr(`FSTCW_OFF_IRQ_STAT, 32'h7);
		wr(`FSTCW_OFF_CMD, 32'h7);
		rd(`FSTCW_OFF_IRQ_STAT);
		`CHK(q, 32'h2)
		`CHK(irq, 1'b0)
		wr(`FSTCW_OFF_IRQ_MASK, 32'h2);
		rd(`FSTCW_OFF_CTRL);
		`CHK(irq, 1'b1)
		wr(`FSTCW_OFF_IRQ_STAT, 32'h2);
		rd(`FSTCW_OFF_IRQ_STAT);
		`CHK({irq, q}, 33'h0)
	endtask
	task automatic t_apb;
		logic [31:0] s;
		rd(8'h2c);
		`CHK({e, q}, 33'h100000000)
		wr(8'h30, 32'h1);
		`CHK(e, 1'b1)
		rd(`FSTCW_OFF_STATUS);
		s = q;
		wr(`FSTCW_OFF_STATUS, 32'hffff);
		`CHK(e, 1'b0)
		rd(`FSTCW_OFF_STATUS);
		`CHK({e, q}, {1'b0, s})
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Whole run is a few hundred cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cc();
		t_ptan();
		t_stack();
		t_tags();
		t_irq();
		t_apb();
		summarize();
	end
endmodule
